// ---- dtec_pkg.sv ----
// Constants, field positions and mode type for the dual timer and
// external interrupt control block. Assumes one 100 MHz clock domain.
// Function
// - Timer one overflow sets its flag; software write or vector ack clears it.
// - Timer zero overflow sets its flag; software or vector ack clears it.
// - Timer one halts while its run bit (control bit 6) is zero.
// - Outside split mode, timer zero halts while its run bit (control bit 4) is zero.
// - Edge mode: interrupt one flag latches on edge until cleared or acked.
// - Level mode: interrupt one flag equals the inverted pin.
// - Interrupt zero flag latches edges in edge mode, mirrors inverted pin in level.
// - Control bit 2 selects level (0) or edge (1) for interrupt one.
// - Control bit 0 selects level (0) or edge (1) for interrupt zero.
// - Timer one gate bit 7 set: count only while interrupt one pin is high.
// - Timer one source bit 6 set: count external pin pulses instead of clocks.
// - Mode bits 5:4 select timer one mode; low nibble mirrors for timer zero.
// - Modes: 5-bit prescale, 16-bit, 8-bit autoreload, split or halt.
// - Timer zero split: low byte run by run zero, high byte by run one.
// - Timer zero gate bit 3 set: count only while interrupt zero pin is high, except the split upper byte.
package dtec_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0L = 8'h8a;
  localparam logic [7:0] ADDR_T1L = 8'h8b;
  localparam logic [7:0] ADDR_T0H = 8'h8c;
  localparam logic [7:0] ADDR_T1H = 8'h8d;
  localparam logic [7:0] ADDR_STAT = 8'ha0;
  localparam logic [7:0] ADDR_MASK = 8'ha1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;
  localparam logic [4:0] PRESCALE_ONE = 5'h01;
  localparam logic [3:0] STAT_ZERO = 4'h0;
  // Control register fields
  localparam int CT_TF1 = 7;
  localparam int CT_TR1 = 6;
  localparam int CT_TF0 = 5;
  localparam int CT_TR0 = 4;
  localparam int CT_IE1 = 3;
  localparam int CT_IT1 = 2;
  localparam int CT_IE0 = 1;
  localparam int CT_IT0 = 0;
  // Mode register fields
  localparam int MD_GATE1 = 7;
  localparam int MD_SRC1 = 6;
  localparam int MD_M1_HI = 5;
  localparam int MD_M1_LO = 4;
  localparam int MD_GATE0 = 3;
  localparam int MD_SRC0 = 2;
  localparam int MD_M0_HI = 1;
  localparam int MD_M0_LO = 0;
  // Interrupt status and mask fields
  localparam int ST_TF1 = 3;
  localparam int ST_TF0 = 2;
  localparam int ST_EX1 = 1;
  localparam int ST_EX0 = 0;
  typedef enum logic [1:0] {
    MODE_PRESCALE,
    MODE_WIDE,
    MODE_RELOAD,
    MODE_SPLIT
  } dtec_mode_t;
endpackage : dtec_pkg

// ---- dtec_pin_sync.sv ----
// Two-stage synchroniser with falling-transition detector for one pin.
// Assumes the pin idles high and is asynchronous to clk.
`timescale 1ns/1ns
module dtec_pin_sync
  import dtec_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinIn,
  output logic pinLevel,
  output logic pinFall
);
  logic meta_reg;
  logic meta_next;
  logic level_reg;
  logic level_next;
  logic last_reg;
  logic last_next;

  always_comb begin
    meta_next = pinIn;
    level_next = meta_reg;
    last_next = level_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b1;
      level_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      level_reg <= level_next;
      last_reg <= last_next;
    end
  end

  assign pinLevel = level_reg;
  // One pulse per high-to-low transition, from settled stages only
  assign pinFall = last_reg & ~level_reg;
endmodule : dtec_pin_sync

// ---- dtec_timer.sv ----
// One timer/counter pair of bytes with the four operating modes.
// Assumes the caller decodes run, gate and source into increment pulses.
`timescale 1ns/1ns
module dtec_timer
  import dtec_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire dtec_mode_t mode,
  input wire logic incLow,
  input wire logic incHigh,
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire logic [7:0] wrData,
  output logic [7:0] countLow,
  output logic [7:0] countHigh,
  output logic ovfLow,
  output logic ovfHigh
);
  logic [7:0] low_reg;
  logic [7:0] low_next;
  logic [7:0] high_reg;
  logic [7:0] high_next;

  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    ovfLow = 1'b0;
    ovfHigh = 1'b0;
    if (incLow) begin
      case (mode)
        MODE_PRESCALE: begin
          low_next = {low_reg[7:5], low_reg[4:0] + PRESCALE_ONE};
          if (low_reg[4:0] == PRESCALE_MAX) begin
            high_next = high_reg + BYTE_ONE;
            ovfLow = (high_reg == BYTE_MAX);
          end
        end
        MODE_WIDE: begin
          {high_next, low_next} = {high_reg, low_reg} + {BYTE_ZERO, BYTE_ONE};
          ovfLow = (low_reg == BYTE_MAX) && (high_reg == BYTE_MAX);
        end
        MODE_RELOAD: begin
          // High byte holds the reload value and never counts here
          low_next = (low_reg == BYTE_MAX) ? high_reg : low_reg + BYTE_ONE;
          ovfLow = (low_reg == BYTE_MAX);
        end
        MODE_SPLIT: begin
          low_next = low_reg + BYTE_ONE;
          ovfLow = (low_reg == BYTE_MAX);
        end
        default: begin
          low_next = low_reg;
        end
      endcase
    end
    if (incHigh && mode == MODE_SPLIT) begin
      high_next = high_reg + BYTE_ONE;
      ovfHigh = (high_reg == BYTE_MAX);
    end
    // Software load takes priority over the count in the same cycle
    if (wrLow) begin
      low_next = wrData;
    end
    if (wrHigh) begin
      high_next = wrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_reg <= BYTE_ZERO;
      high_reg <= BYTE_ZERO;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  assign countLow = low_reg;
  assign countHigh = high_reg;
endmodule : dtec_timer

// ---- dtec_timer_ctrl.sv ----
// Top of the dual timer and external interrupt control block: register
// port, run/gate/source decode, flags and the summary interrupt.
// Assumes a single-cycle strobe register master on clk and the CPU
// pulsing a vector acknowledge when it enters each service routine.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module dtec_timer_ctrl
  import dtec_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic countPinZero,
  input wire logic countPinOne,
  input wire logic irqPinZero_n,
  input wire logic irqPinOne_n,
  input wire logic vecAckTimerZero,
  input wire logic vecAckTimerOne,
  input wire logic vecAckExtZero,
  input wire logic vecAckExtOne,
  output logic irq
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [3:0] stat_reg;
  logic [3:0] stat_next;
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;
  logic cnt0Level;
  logic cnt0Fall;
  logic cnt1Level;
  logic cnt1Fall;
  logic irq0Level;
  logic irq0Fall;
  logic irq1Level;
  logic irq1Fall;
  logic [7:0] t0Low;
  logic [7:0] t0High;
  logic [7:0] t1Low;
  logic [7:0] t1High;
  logic ovf0Low;
  logic ovf0High;
  logic ovf1Low;
  logic unusedOvf1High;
  logic wrCtrl;
  logic wrT0;
  logic wrT1;
  logic inc0;
  logic inc0High;
  logic inc1;
  logic tf1Set;
  logic tf0Set;
  dtec_mode_t mode0;
  dtec_mode_t mode1;
  logic [3:0] events;

  // Hardware set beats software or vector clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  // Edge mode latches; level mode follows the inverted pin
  function automatic logic ext_flag(input logic cur, input logic edgeMode,
                                    input logic fall, input logic level, input logic ack);
    ext_flag = edgeMode ? flag_next(cur, fall, ack) : ~level;
  endfunction : ext_flag

  dtec_pin_sync u_sync_cnt0 (
    .clk(clk), .reset_n(reset_n), .pinIn(countPinZero),
    .pinLevel(cnt0Level), .pinFall(cnt0Fall)
  );
  dtec_pin_sync u_sync_cnt1 (
    .clk(clk), .reset_n(reset_n), .pinIn(countPinOne),
    .pinLevel(cnt1Level), .pinFall(cnt1Fall)
  );
  dtec_pin_sync u_sync_irq0 (
    .clk(clk), .reset_n(reset_n), .pinIn(irqPinZero_n),
    .pinLevel(irq0Level), .pinFall(irq0Fall)
  );
  dtec_pin_sync u_sync_irq1 (
    .clk(clk), .reset_n(reset_n), .pinIn(irqPinOne_n),
    .pinLevel(irq1Level), .pinFall(irq1Fall)
  );

  assign wrCtrl = regWrEn && (regAddr == ADDR_CTRL);
  assign wrT0 = regWrEn && (regAddr == ADDR_T0L || regAddr == ADDR_T0H);
  assign wrT1 = regWrEn && (regAddr == ADDR_T1L || regAddr == ADDR_T1H);
  assign mode0 = dtec_mode_t'(mode_reg[MD_M0_HI:MD_M0_LO]);
  assign mode1 = dtec_mode_t'(mode_reg[MD_M1_HI:MD_M1_LO]);

  always_comb begin
    // Timer zero: run, gate on interrupt zero pin, clock or pin source
    inc0 = ctrl_reg[CT_TR0]
      && (!mode_reg[MD_GATE0] || irq0Level)
      && (mode_reg[MD_SRC0] ? cnt0Fall : 1'b1);
    // Split mode borrows run one for the upper byte, internal clock only
    inc0High = ctrl_reg[CT_TR1];
    // Timer one halts in split mode but keeps its count
    inc1 = ctrl_reg[CT_TR1]
      && (!mode_reg[MD_GATE1] || irq1Level)
      && (mode_reg[MD_SRC1] ? cnt1Fall : 1'b1)
      && (mode1 != MODE_SPLIT);
  end

  dtec_timer u_timer0 (
    .clk(clk), .reset_n(reset_n), .mode(mode0),
    .incLow(inc0), .incHigh(inc0High),
    .wrLow(regWrEn && regAddr == ADDR_T0L), .wrHigh(regWrEn && regAddr == ADDR_T0H),
    .wrData(regWrData), .countLow(t0Low), .countHigh(t0High),
    .ovfLow(ovf0Low), .ovfHigh(ovf0High)
  );
  dtec_timer u_timer1 (
    .clk(clk), .reset_n(reset_n), .mode(mode1),
    .incLow(inc1), .incHigh(1'b0),
    .wrLow(regWrEn && regAddr == ADDR_T1L), .wrHigh(regWrEn && regAddr == ADDR_T1H),
    .wrData(regWrData), .countLow(t1Low), .countHigh(t1High),
    .ovfLow(ovf1Low), .ovfHigh(unusedOvf1High)
  );

  // Upper byte of split timer zero reports through the timer one flag
  assign tf1Set = ovf1Low | ovf0High;
  assign tf0Set = ovf0Low;

  always_comb begin
    ctrl_next = wrCtrl ? regWrData : ctrl_reg;
    mode_next = (regWrEn && regAddr == ADDR_MODE) ? regWrData : mode_reg;
    ctrl_next[CT_TF1] = flag_next(ctrl_next[CT_TF1], tf1Set, vecAckTimerOne);
    ctrl_next[CT_TF0] = flag_next(ctrl_next[CT_TF0], tf0Set, vecAckTimerZero);
    ctrl_next[CT_IE1] = ext_flag(ctrl_next[CT_IE1], ctrl_next[CT_IT1],
                                 irq1Fall, irq1Level, vecAckExtOne);
    ctrl_next[CT_IE0] = ext_flag(ctrl_next[CT_IE0], ctrl_next[CT_IT0],
                                 irq0Fall, irq0Level, vecAckExtZero);
  end

  always_comb begin
    events = STAT_ZERO;
    events[ST_TF1] = tf1Set;
    events[ST_TF0] = tf0Set;
    events[ST_EX1] = irq1Fall;
    events[ST_EX0] = irq0Fall;
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (regWrEn && regAddr == ADDR_STAT) begin
      stat_next = stat_reg & ~regWrData[3:0];
    end
    // A new event in the clearing cycle stays set
    stat_next = stat_next | events;
    if (regWrEn && regAddr == ADDR_MASK) begin
      mask_next = regWrData[3:0];
    end
  end

  always_comb begin
    rd_next = BYTE_ZERO;
    if (regRdEn) begin
      case (regAddr)
        ADDR_CTRL: rd_next = ctrl_reg;
        ADDR_MODE: rd_next = mode_reg;
        ADDR_T0L: rd_next = t0Low;
        ADDR_T1L: rd_next = t1Low;
        ADDR_T0H: rd_next = t0High;
        ADDR_T1H: rd_next = t1High;
        ADDR_STAT: rd_next = {4'h0, stat_reg};
        ADDR_MASK: rd_next = {4'h0, mask_reg};
        default: rd_next = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      mode_reg <= MODE_RESET;
      stat_reg <= STAT_ZERO;
      mask_reg <= STAT_ZERO;
      rd_reg <= BYTE_ZERO;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
    end
  end

  assign regRdData = rd_reg;
  assign irq = |(stat_reg & mask_reg);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Timer flags and status events
  a_tf1_overflow_set: assert property (
    tf1Set |=> ctrl_reg[CT_TF1])
    else $error("timer one flag not set on overflow");
  a_tf1_ack_clear: assert property (
    ctrl_reg[CT_TF1] && vecAckTimerOne && !tf1Set && !wrCtrl |=> !ctrl_reg[CT_TF1])
    else $error("timer one flag not cleared by vector ack");
  a_tf0_overflow_set: assert property (
    tf0Set |=> ctrl_reg[CT_TF0])
    else $error("timer zero flag not set on overflow");
  a_tf0_ack_clear: assert property (
    ctrl_reg[CT_TF0] && vecAckTimerZero && !tf0Set && !wrCtrl |=> !ctrl_reg[CT_TF0])
    else $error("timer zero flag not cleared by vector ack");
  a_tf1_status_set: assert property (
    tf1Set |=> stat_reg[ST_TF1])
    else $error("timer one event missing from status");
  a_tf0_status_set: assert property (
    tf0Set |=> stat_reg[ST_TF0])
    else $error("timer zero event missing from status");

  // Run, gate and source decode
  a_t1_run_halt: assert property (
    !ctrl_reg[CT_TR1] && !wrT1 |=> $stable({t1High, t1Low}))
    else $error("timer one moved while halted");
  a_t0_run_halt: assert property (
    !ctrl_reg[CT_TR0] && !wrT0 && mode0 != MODE_SPLIT |=> $stable({t0High, t0Low}))
    else $error("timer zero moved while halted");
  a_ctrl_run_write: assert property (
    wrCtrl |=> ctrl_reg[CT_TR1] == $past(regWrData[CT_TR1])
      && ctrl_reg[CT_TR0] == $past(regWrData[CT_TR0]))
    else $error("run bits not loaded by control write");
  a_t1_gate_block: assert property (
    mode_reg[MD_GATE1] && !irq1Level && !wrT1 |=> $stable({t1High, t1Low}))
    else $error("gated timer one counted with pin low");
  a_t0_gate_block: assert property (
    mode_reg[MD_GATE0] && !irq0Level && !wrT0 |=> $stable(t0Low))
    else $error("gated timer zero counted with pin low");
  a_t1_source_pin: assert property (
    mode_reg[MD_SRC1] && !cnt1Fall && !wrT1 |=> $stable({t1High, t1Low}))
    else $error("timer one counted without pin pulse");
  a_t0_source_pin: assert property (
    mode_reg[MD_SRC0] && !cnt0Fall && !wrT0 |=> $stable(t0Low))
    else $error("timer zero counted without pin pulse");
  a_fall_pulse_once: assert property (
    cnt0Fall |=> !cnt0Fall)
    else $error("count pin fall pulse lasted two cycles");

  // Operating modes
  a_mode_write: assert property (
    regWrEn && regAddr == ADDR_MODE |=> mode_reg == $past(regWrData))
    else $error("mode register not loaded by write");
  a_t1_prescale_carry: assert property (
    mode1 == MODE_PRESCALE && inc1 && !wrT1 && t1Low[4:0] == PRESCALE_MAX
    |=> t1High == $past(t1High) + BYTE_ONE)
    else $error("prescale carry did not reach timer one high byte");
  a_t0_wide_wrap: assert property (
    mode0 == MODE_WIDE && inc0 && !wrT0 && t0Low == BYTE_MAX && t0High == BYTE_MAX
    |=> t0Low == BYTE_ZERO && t0High == BYTE_ZERO && ctrl_reg[CT_TF0])
    else $error("sixteen-bit timer zero did not wrap with flag");
  a_t1_reload_value: assert property (
    mode1 == MODE_RELOAD && inc1 && !wrT1 && t1Low == BYTE_MAX |=> t1Low == $past(t1High))
    else $error("timer one did not reload from high byte");
  a_t1_split_hold: assert property (
    mode1 == MODE_SPLIT && !wrT1 |=> $stable({t1High, t1Low}))
    else $error("timer one moved in mode three");
  a_split_high_run: assert property (
    mode0 == MODE_SPLIT && ctrl_reg[CT_TR1] && !wrT0 |=> t0High == $past(t0High) + BYTE_ONE)
    else $error("split upper byte did not follow run one");
  a_split_low_run: assert property (
    mode0 == MODE_SPLIT && !ctrl_reg[CT_TR0] && !wrT0 |=> $stable(t0Low))
    else $error("split lower byte moved without run zero");

  // External interrupt flags
  a_ext1_edge_latch: assert property (
    ctrl_reg[CT_IT1] && !wrCtrl && irq1Fall |=> ctrl_reg[CT_IE1])
    else $error("interrupt one edge not latched");
  a_ext1_edge_hold: assert property (
    ctrl_reg[CT_IT1] && ctrl_reg[CT_IE1] && !wrCtrl && !vecAckExtOne |=> ctrl_reg[CT_IE1])
    else $error("interrupt one edge flag dropped");
  a_ext1_ack_clear: assert property (
    ctrl_reg[CT_IT1] && vecAckExtOne && !irq1Fall && !wrCtrl |=> !ctrl_reg[CT_IE1])
    else $error("interrupt one flag not cleared by vector ack");
  a_ext1_level_follow: assert property (
    !ctrl_reg[CT_IT1] && !wrCtrl |=> ctrl_reg[CT_IE1] == !$past(irq1Level))
    else $error("interrupt one level flag does not follow pin");
  a_ext0_edge_latch: assert property (
    ctrl_reg[CT_IT0] && !wrCtrl && irq0Fall |=> ctrl_reg[CT_IE0])
    else $error("interrupt zero edge not latched");
  a_ext0_edge_hold: assert property (
    ctrl_reg[CT_IT0] && ctrl_reg[CT_IE0] && !wrCtrl && !vecAckExtZero |=> ctrl_reg[CT_IE0])
    else $error("interrupt zero edge flag dropped");
  a_ext0_level_follow: assert property (
    !ctrl_reg[CT_IT0] && !wrCtrl |=> ctrl_reg[CT_IE0] == !$past(irq0Level))
    else $error("interrupt zero level flag does not follow pin");
  a_ext1_status_set: assert property (
    irq1Fall |=> stat_reg[ST_EX1])
    else $error("interrupt one fall missing from status");
  a_ext0_status_set: assert property (
    irq0Fall |=> stat_reg[ST_EX0])
    else $error("interrupt zero fall missing from status");

  // Register port and status clearing
  a_rd_data_idle: assert property (
    !regRdEn |=> regRdData == BYTE_ZERO)
    else $error("read data present without a read strobe");
  a_stat_write_clear: assert property (
    regWrEn && regAddr == ADDR_STAT && regWrData[ST_EX0] && !irq0Fall |=> !stat_reg[ST_EX0])
    else $error("status bit not cleared by writing one");

  c_tf1_overflow: cover property (tf1Set ##1 ctrl_reg[CT_TF1]);
  c_ext0_edge: cover property (ctrl_reg[CT_IT0] && irq0Fall ##1 ctrl_reg[CT_IE0]);
  c_split_high_ovf: cover property (mode0 == MODE_SPLIT && ovf0High);
  c_irq_raised: cover property (!irq ##1 irq);
  c_t0_gate_held: cover property (mode_reg[MD_GATE0] && ctrl_reg[CT_TR0] && !irq0Level);
endmodule : dtec_timer_ctrl

// ---- dtec_pin_model.sv ----
// Model of the external pins: two count inputs and two active-low interrupts.
// Assumes the pins idle high and change only just after a rising clk edge.
`timescale 1ns/1ns
module dtec_pin_model (
  input wire logic clk,
  output logic countPinZero,
  output logic countPinOne,
  output logic irqPinZero_n,
  output logic irqPinOne_n
);
  initial begin
    countPinZero = 1'b1;
    countPinOne = 1'b1;
    irqPinZero_n = 1'b1;
    irqPinOne_n = 1'b1;
  end

  // Low and high phases last 3 clocks so the two-flop sync never misses one
  task automatic pulse(input int idx);
    @(posedge clk);
    if (idx == 0) countPinZero <= 1'b0;
    else countPinOne <= 1'b0;
    repeat (3) @(posedge clk);
    if (idx == 0) countPinZero <= 1'b1;
    else countPinOne <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic irqLevel(input int idx, input logic lvl);
    @(posedge clk);
    if (idx == 0) irqPinZero_n <= lvl;
    else irqPinOne_n <= lvl;
    repeat (4) @(posedge clk);
  endtask : irqLevel
endmodule : dtec_pin_model

// ---- dtec_timer_ctrl_test.sv ----
// Self-checking bench for the dual timer and interrupt control block.
// Assumes the pin model drives all external pins; registers via strobe port.
`timescale 1ns/1ns
module dtec_timer_ctrl_test;
  import dtec_pkg::*;
  logic clk = 1'b0;
  logic reset_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic [3:0] vecAck;
  logic irq;
  logic cp0, cp1, ip0, ip1;
  int failures = 0;
  int compares = 0;

  always #5 clk = ~clk;

  dtec_pin_model pins (.clk(clk), .countPinZero(cp0), .countPinOne(cp1),
    .irqPinZero_n(ip0), .irqPinOne_n(ip1));

  dtec_timer_ctrl DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .countPinZero(cp0), .countPinOne(cp1),
    .irqPinZero_n(ip0), .irqPinOne_n(ip1), .vecAckTimerZero(vecAck[0]),
    .vecAckTimerOne(vecAck[1]), .vecAckExtZero(vecAck[2]),
    .vecAckExtOne(vecAck[3]), .irq(irq));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, regRdData);
    // The answer stands one cycle only, then the port reads zero
    @(posedge clk);
    #1;
    chk("read idle", BYTE_ZERO, regRdData);
  endtask : rd

  task automatic ack(input int idx);
    @(posedge clk);
    vecAck[idx] <= 1'b1;
    @(posedge clk);
    vecAck[idx] <= 1'b0;
    #1;
  endtask : ack

  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, failures);
  endtask : done

  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    reset_n <= 1'b0;
    regAddr <= BYTE_ZERO;
    regWrData <= BYTE_ZERO;
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    vecAck <= STAT_ZERO;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_MODE, MODE_RESET);
    for (int i = 0; i < 4; i++) rd(ADDR_T0L + 8'(i), 8'h00);
    wr(8'h90, 8'h5a);
    rd(8'h90, 8'h00);
    done("reset");
    // Timer zero 16-bit on external pulses
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_T0L, 8'hff);
    wr(ADDR_T0H, 8'hff);
    wr(ADDR_CTRL, 8'h10);
    pins.pulse(0);
    rd(ADDR_T0L, 8'h00);
    rd(ADDR_T0H, 8'h00);
    rd(ADDR_CTRL, 8'h30);
    ack(0);
    rd(ADDR_CTRL, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    pins.pulse(0);
    rd(ADDR_T0L, 8'h00);
    done("wide");
    // Prescale mode: carry out of the 5-bit low part
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_T0L, 8'h1f);
    wr(ADDR_T0H, 8'hff);
    wr(ADDR_CTRL, 8'h10);
    pins.pulse(0);
    rd(ADDR_T0L, 8'h00);
    rd(ADDR_CTRL, 8'h30);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    done("prescale");
    // Timer zero on internal clocks, gated by its interrupt pin
    wr(ADDR_MODE, 8'h09);
    pins.irqLevel(0, 1'b0);
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_T0L, 8'h00);
    pins.irqLevel(0, 1'b1);
    // Run bit is high before exactly two edges between back-to-back writes
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_T0L, 8'h02);
    rd(ADDR_T0H, 8'h00);
    done("gate_zero");
    // Timer one external source, then gated by its interrupt pin
    wr(ADDR_MODE, 8'h50);
    wr(ADDR_CTRL, 8'h40);
    for (int i = 0; i < 3; i++) pins.pulse(1);
    rd(ADDR_T1L, 8'h03);
    wr(ADDR_MODE, 8'hd0);
    pins.irqLevel(1, 1'b0);
    pins.pulse(1);
    pins.pulse(1);
    rd(ADDR_T1L, 8'h03);
    pins.irqLevel(1, 1'b1);
    pins.pulse(1);
    rd(ADDR_T1L, 8'h04);
    wr(ADDR_CTRL, 8'h00);
    pins.pulse(1);
    rd(ADDR_T1L, 8'h04);
    done("source_gate");
    // Timer one autoreload overflow
    wr(ADDR_MODE, 8'h60);
    wr(ADDR_T1H, 8'h80);
    wr(ADDR_T1L, 8'hff);
    wr(ADDR_CTRL, 8'h40);
    pins.pulse(1);
    rd(ADDR_T1L, 8'h80);
    rd(ADDR_CTRL, 8'hc0);
    ack(1);
    rd(ADDR_CTRL, 8'h40);
    done("reload");
    // Split timer zero; timer one in mode three holds its count
    wr(ADDR_MODE, 8'h37);
    wr(ADDR_T1L, 8'h00);
    wr(ADDR_T0L, 8'h00);
    wr(ADDR_CTRL, 8'h50);
    pins.pulse(0);
    pins.pulse(1);
    rd(ADDR_T1L, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_T0H, 8'h00);
    pins.pulse(0);
    rd(ADDR_T0H, 8'h00);
    rd(ADDR_T0L, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    done("split");
    // External interrupts, edge then level, for both pins
    wr(ADDR_STAT, 8'h0f);
    for (int i = 0; i < 2; i++) begin
      logic [7:0] tb, fb;
      tb = (i == 0) ? 8'h01 : 8'h04;
      fb = (i == 0) ? 8'h02 : 8'h08;
      wr(ADDR_CTRL, tb);
      pins.irqLevel(i, 1'b0);
      pins.irqLevel(i, 1'b1);
      rd(ADDR_CTRL, tb | fb);
      ack(2 + i);
      rd(ADDR_CTRL, tb);
      wr(ADDR_CTRL, 8'h00);
      pins.irqLevel(i, 1'b0);
      rd(ADDR_CTRL, fb);
      pins.irqLevel(i, 1'b1);
      rd(ADDR_CTRL, 8'h00);
    end
    done("ext_irq");
    // Status, mask and the summary interrupt line
    rd(ADDR_STAT, 8'h03);
    chk("irq", 8'h00, {7'h00, irq});
    wr(ADDR_MASK, 8'h02);
    chk("irq", 8'h01, {7'h00, irq});
    rd(ADDR_MASK, 8'h02);
    wr(ADDR_STAT, 8'h02);
    chk("irq", 8'h00, {7'h00, irq});
    rd(ADDR_STAT, 8'h01);
    done("interrupt");
    end_of_test();
  end
endmodule : dtec_timer_ctrl_test
